// File: verilog/pucv_pkg.sv
// Shared constants and types of the positioning unit conversion block.
// Assumes a single system clock and the plain register port of the block.
package pucv_pkg;

   // Register indices on the plain register port.
   localparam logic [3:0] OFS_UNIT = 4'h0;
   localparam logic [3:0] OFS_PPR = 4'h1;
   localparam logic [3:0] OFS_TRAVEL = 4'h2;
   localparam logic [3:0] OFS_MAXSPD = 4'h3;
   localparam logic [3:0] OFS_VALUE = 4'h4;
   localparam logic [3:0] OFS_CTRL = 4'h5;
   localparam logic [3:0] OFS_STATUS = 4'h6;
   localparam logic [3:0] OFS_PULSES = 4'h7;
   localparam logic [3:0] OFS_FREQ = 4'h8;
   localparam logic [3:0] OFS_MAXFREQ = 4'h9;

   // Control word field positions.
   localparam int unsigned CTRL_CMD_LSB = 0;
   localparam int unsigned CTRL_INTERP_BIT = 2;

   // Status word field positions.
   localparam int unsigned STAT_BUSY_BIT = 0;
   localparam int unsigned STAT_DONE_BIT = 1;
   localparam int unsigned STAT_DIV0_BIT = 2;
   localparam int unsigned STAT_UNIT_BIT = 3;
   localparam int unsigned STAT_CLAMP_BIT = 4;

   // Unit system codes.
   localparam logic [1:0] UNIT_MECH = 2'h0;
   localparam logic [1:0] UNIT_MOTOR = 2'h1;
   localparam logic [1:0] UNIT_COMP = 2'h2;

   // Values after reset.
   localparam logic [1:0] RST_UNIT = 2'h2;
   localparam logic [31:0] RST_PPR = 32'h00000FA0;
   localparam logic [31:0] RST_TRAVEL = 32'h00001388;
   localparam logic [31:0] RST_MAXSPD = 32'h00030D40;
   localparam logic [31:0] RST_MAXFREQ = 32'h00030D40;

   // Arithmetic constants: cm/min to um/s is times 10^4, over 60.
   localparam logic [31:0] SPD_SCALE = 32'h00002710;
   localparam logic [31:0] SPD_DIV = 32'h0000003C;
   localparam logic [31:0] UNIT_SCALE = 32'h00000001;

   // Frequency ceilings in Hz.
   localparam logic [31:0] FREQ_MAX_HZ = 32'h00030D40;
   localparam logic [31:0] FREQ_INTERP_HZ = 32'h000186A0;

   // Conversion commands.
   typedef enum logic [1:0] {
      CMD_NONE = 2'h0,
      CMD_DIST = 2'h1,
      CMD_SPEED = 2'h2,
      CMD_MAXSPD = 2'h3
   } pucv_cmd_type;

   // Conversion sequencer states.
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_MUL1 = 5'b00010,
      ST_MUL2 = 5'b00100,
      ST_DIVGO = 5'b01000,
      ST_WAIT = 5'b10000
   } pucv_state_type;

   // Register port request group.
   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } pucv_bus_type;

endpackage

// File: verilog/pucv_mul.sv
// Registered unsigned multiplier used by the conversion sequencer.
// Assumes operands are held steady in the cycle before the product is used.
`timescale 1ns/100ps
module pucv_mul #(
   parameter int unsigned AW = 48,
   parameter int unsigned BW = 32
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [AW-1:0] opA,
   input wire logic [BW-1:0] opB,
   output logic [AW+BW-1:0] prod
);
   typedef struct packed {
      logic [AW+BW-1:0] prod;
   } pucv_mul_st_type;

   pucv_mul_st_type s_q;
   pucv_mul_st_type s_d;

   if (AW < 1 || BW < 1) begin : g_chk
      $error("pucv_mul: operand widths must be positive.");
   end

   // The full width product keeps every bit, so nothing overflows.
   always_comb begin
      s_d.prod = {{BW{1'b0}}, opA} * {{AW{1'b0}}, opB};
   end

   // Product register.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign prod = s_q.prod;
endmodule

// File: verilog/pucv_div.sv
// Serial restoring divider, one quotient bit per clock.
// Assumes start is a one-cycle pulse given only while not busy.
`timescale 1ns/100ps
module pucv_div #(
   parameter int unsigned NW = 80,
   parameter int unsigned DW = 40
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic start,
   input wire logic [NW-1:0] num,
   input wire logic [DW-1:0] den,
   output logic busy,
   output logic done,
   output logic divZero,
   output logic [NW-1:0] quo
);
   typedef struct packed {
      logic busy;
      logic done;
      logic divZero;
      logic [7:0] cnt;
      logic [DW:0] rem;
      logic [DW-1:0] den;
      logic [NW-1:0] quo;
   } pucv_div_st_type;

   pucv_div_st_type s_q;
   pucv_div_st_type s_d;
   logic [DW:0] remShift;

   if (NW < 2 || NW > 255 || DW < 1) begin : g_chk
      $error("pucv_div: widths out of the supported range.");
   end

   // Shift the next dividend bit in and subtract when the divisor fits.
   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      remShift = {s_q.rem[DW-1:0], s_q.quo[NW-1]};
      if (start) begin
         s_d.den = den;
         s_d.quo = num;
         s_d.rem = '0;
         s_d.cnt = 8'(NW);
         s_d.divZero = (den == '0);
         s_d.busy = (den != '0);
         s_d.done = (den == '0);
      end else if (s_q.busy) begin
         if (remShift >= {1'b0, s_q.den}) begin
            s_d.rem = remShift - {1'b0, s_q.den};
            s_d.quo = {s_q.quo[NW-2:0], 1'b1};
         end else begin
            s_d.rem = remShift;
            s_d.quo = {s_q.quo[NW-2:0], 1'b0};
         end
         s_d.cnt = s_q.cnt - 8'h01;
         if (s_q.cnt == 8'h01) begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
         end
      end
   end

   // Divider state register.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign busy = s_q.busy;
   assign done = s_q.done;
   assign divZero = s_q.divZero;
   assign quo = s_q.quo;
endmodule

// File: verilog/pucv_unit_conv.sv
// Unit conversion core of a pulse-train positioning unit: settings
// registers, distance and speed conversion, and output frequency limits.
// Assumes one system clock and a register master on the same clock.
// Assumes the master keeps the settings still while a conversion runs.
`timescale 1ns/100ps

module pucv_unit_conv
   import pucv_pkg::*;
#(
   parameter bit TWO_AXIS = 1'b1,
   parameter int unsigned NUM_W = 80,
   parameter int unsigned DEN_W = 40
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire pucv_bus_type busReq,
   output logic [31:0] rdData,
   output logic [31:0] pulseCount,
   output logic [31:0] pulseFreq,
   output logic convBusy,
   output logic convDone
);
   localparam int unsigned MUL_AW = NUM_W - 32;

   // Register map on the plain port, by word index:
   //    0  unit system code in bits 1:0.
   //    1  output pulses per motor revolution.
   //    2  travel per motor revolution in micrometres.
   //    3  maximum speed, in the units that the unit code selects.
   //    4  input value of the next conversion.
   //    5  control: command in bits 1:0, interpolation flag in bit 2.
   //    6  status: busy, done, zero divisor, bad unit code, clamped.
   //    7  last distance result in pulses.
   //    8  last operating speed result in hertz.
   //    9  converted maximum output frequency in hertz.
   // Unmapped indices read as zero and ignore writes.

   // Whole state of the block.
   typedef struct packed {
      // Software settings.
      logic [1:0] unitSystem;
      logic [31:0] pulsesPerRev;
      logic [31:0] travelPerRev;
      logic [31:0] maxSpeed;
      logic [31:0] inValue;
      logic interp;
      // Sequencer and its flags.
      pucv_cmd_type cmd;
      pucv_state_type st;
      logic busy;
      logic done;
      logic errDiv0;
      logic errUnit;
      logic clamped;
      // Results and read data.
      logic [31:0] pulses;
      logic [31:0] freq;
      logic [31:0] maxFreq;
      logic [31:0] rdata;
   } pucv_top_st_type;

   pucv_top_st_type s_q;
   pucv_top_st_type s_d;

   // Multiplier and divider hookup, and the derived speed ceiling.
   logic [MUL_AW-1:0] mulA;
   logic [31:0] mulB;
   logic [NUM_W-1:0] mulP;
   logic divStart;
   logic [DEN_W-1:0] divDen;
   logic divBusy;
   logic divDone;
   logic divZero;
   logic [NUM_W-1:0] divQuo;
   logic [31:0] quoSat;
   logic [31:0] speedLimit;
   logic interpNow;
   pucv_cmd_type wrCmd;

   // The sequencer slices the product at fixed positions, so only these
   // widths are served.
   if (NUM_W != 80 || DEN_W < 40 || DEN_W > 64) begin : g_chk
      $error("pucv_unit_conv: numerator must be 80 bits, divisor 40..64.");
   end

   // Lower of a value and a ceiling.
   // Both operands are unsigned, so a large request never wraps below.
   function automatic logic [31:0] clampTo(input logic [31:0] v,
                                           input logic [31:0] lim);
      clampTo = (v > lim) ? lim : v;
   endfunction

   // Product stage: first scale, then times pulses per revolution.
   // Operands are zero outside the two product states, so the product
   // register holds zero while the sequencer is idle.
   pucv_mul #(
      .AW(MUL_AW),
      .BW(32)
   ) uMul (
      .mclk(mclk),
      .nrst(nrst),
      .opA(mulA),
      .opB(mulB),
      .prod(mulP)
   );

   // Quotient stage for the per-revolution division.
   // It is started for one cycle from the load state only, and the
   // sequencer waits in its own state, so two runs never overlap.
   pucv_div #(
      .NW(NUM_W),
      .DW(DEN_W)
   ) uDiv (
      .mclk(mclk),
      .nrst(nrst),
      .start(divStart),
      .num(mulP),
      .den(divDen),
      .busy(divBusy),
      .done(divDone),
      .divZero(divZero),
      .quo(divQuo)
   );

   // Quotients that do not fit 32 bits saturate instead of wrapping.
   // A wrapped count would command a short move to the wrong place.
   assign quoSat = (|divQuo[NUM_W-1:32]) ? 32'hFFFFFFFF : divQuo[31:0];

   // Operating speed ceiling: the converted maximum, and on the two-axis
   // build the interpolation ceiling while interpolated motion runs. A
   // command write carries its own interpolation flag, so the ceiling of
   // that command follows the written bit, not the one stored before it.
   always_comb begin
      interpNow = s_q.interp;
      if (busReq.wr && busReq.addr == OFS_CTRL) begin
         interpNow = busReq.wdata[CTRL_INTERP_BIT];
      end
      speedLimit = s_q.maxFreq;
      if (TWO_AXIS && interpNow) begin
         speedLimit = clampTo(s_q.maxFreq, FREQ_INTERP_HZ);
      end
   end

   // Command field of a write to the control word.
   assign wrCmd = pucv_cmd_type'(busReq.wdata[CTRL_CMD_LSB +: 2]);

   // Timing of an arithmetic run, counted from the edge that takes the
   // command: the first product is registered one edge later and the
   // second one edge after that. The divider is loaded at the third edge
   // and takes one edge per quotient bit; the result lands one edge after
   // the divider reports done. With an 80-bit numerator busy therefore
   // stays high for 84 cycles. A zero divisor is reported by the divider
   // at once, so that run ends after four cycles. Pass-through commands
   // finish at the taking edge itself and never raise busy.

   // Register writes, reads and the conversion sequencer.
   always_comb begin
      s_d = s_q;
      mulA = '0;
      mulB = '0;
      divStart = 1'b0;
      divDen = '0;
      // Settings may be rewritten at any time; a conversion samples them as
      // it runs, so software finishes setting up before it starts one.
      if (busReq.wr) begin
         unique case (busReq.addr)
            OFS_UNIT: s_d.unitSystem = busReq.wdata[1:0];
            OFS_PPR: s_d.pulsesPerRev = busReq.wdata;
            OFS_TRAVEL: s_d.travelPerRev = busReq.wdata;
            OFS_MAXSPD: s_d.maxSpeed = busReq.wdata;
            OFS_VALUE: s_d.inValue = busReq.wdata;
            OFS_CTRL: s_d.interp = busReq.wdata[CTRL_INTERP_BIT];
            default: s_d.rdata = s_q.rdata;
         endcase
      end
      // Read data stand only in the cycle after the read strobe.
      // Unmapped indices read as zero, like any cycle without a read.
      s_d.rdata = '0;
      if (busReq.rd) begin
         unique case (busReq.addr)
            OFS_UNIT: s_d.rdata = {30'h00000000, s_q.unitSystem};
            OFS_PPR: s_d.rdata = s_q.pulsesPerRev;
            OFS_TRAVEL: s_d.rdata = s_q.travelPerRev;
            OFS_MAXSPD: s_d.rdata = s_q.maxSpeed;
            OFS_VALUE: s_d.rdata = s_q.inValue;
            OFS_CTRL: s_d.rdata = {29'h00000000, s_q.interp, s_q.cmd};
            OFS_STATUS: s_d.rdata = {27'h0000000, s_q.clamped, s_q.errUnit,
                                     s_q.errDiv0, s_q.done, s_q.busy};
            OFS_PULSES: s_d.rdata = s_q.pulses;
            OFS_FREQ: s_d.rdata = s_q.freq;
            OFS_MAXFREQ: s_d.rdata = s_q.maxFreq;
            default: s_d.rdata = '0;
         endcase
      end
      unique case (s_q.st)
         ST_IDLE: begin
            // A command write while busy is ignored by leaving this state.
            if (busReq.wr && busReq.addr == OFS_CTRL && wrCmd != CMD_NONE) begin
               s_d.cmd = wrCmd;
               s_d.done = 1'b1;
               s_d.errDiv0 = 1'b0;
               s_d.errUnit = 1'b0;
               s_d.clamped = 1'b0;
               unique case (s_q.unitSystem)
                  UNIT_MOTOR: begin
                     // Pulses and hertz pass straight through.
                     // The per-revolution settings are never read here.
                     unique case (wrCmd)
                        CMD_DIST: s_d.pulses = s_q.inValue;
                        CMD_SPEED: begin
                           s_d.freq = clampTo(s_q.inValue, speedLimit);
                           s_d.clamped = (s_q.inValue > speedLimit);
                        end
                        default: begin
                           s_d.maxFreq = clampTo(s_q.maxSpeed, FREQ_MAX_HZ);
                           s_d.clamped = (s_q.maxSpeed > FREQ_MAX_HZ);
                        end
                     endcase
                  end
                  UNIT_COMP: begin
                     // Distance goes through the arithmetic, speeds are hertz.
                     // Speeds skip the per-revolution settings entirely.
                     unique case (wrCmd)
                        CMD_DIST: begin
                           s_d.done = 1'b0;
                           s_d.busy = 1'b1;
                           s_d.st = ST_MUL1;
                        end
                        CMD_SPEED: begin
                           s_d.freq = clampTo(s_q.inValue, speedLimit);
                           s_d.clamped = (s_q.inValue > speedLimit);
                        end
                        default: begin
                           s_d.maxFreq = clampTo(s_q.maxSpeed, FREQ_MAX_HZ);
                           s_d.clamped = (s_q.maxSpeed > FREQ_MAX_HZ);
                        end
                     endcase
                  end
                  UNIT_MECH: begin
                     s_d.done = 1'b0;
                     s_d.busy = 1'b1;
                     s_d.st = ST_MUL1;
                  end
                  default: s_d.errUnit = 1'b1;
               endcase
            end
         end
         ST_MUL1: begin
            // Speeds are scaled by 10^4 first; distances by one.
            mulA = (s_q.cmd == CMD_MAXSPD) ? MUL_AW'(s_q.maxSpeed)
                                           : MUL_AW'(s_q.inValue);
            mulB = (s_q.cmd == CMD_DIST) ? UNIT_SCALE : SPD_SCALE;
            s_d.st = ST_MUL2;
         end
         ST_MUL2: begin
            // Multiplying before dividing keeps the fraction until the end.
            mulA = mulP[MUL_AW-1:0];
            mulB = s_q.pulsesPerRev;
            s_d.st = ST_DIVGO;
         end
         ST_DIVGO: begin
            // Divisor is travel, or travel times 60 for a cm/min speed.
            // Sixty times a 32-bit travel still fits the divisor width.
            divStart = 1'b1;
            if (s_q.cmd == CMD_DIST) begin
               divDen = DEN_W'(s_q.travelPerRev);
            end else begin
               divDen = DEN_W'(s_q.travelPerRev) * DEN_W'(SPD_DIV);
            end
            s_d.st = ST_WAIT;
         end
         ST_WAIT: begin
            // The quotient truncates toward zero; a zero divisor is an error.
            // A zero divisor leaves the old results in place, so software
            // sees the error flag instead of a wrong pulse count.
            if (divDone) begin
               s_d.st = ST_IDLE;
               s_d.busy = 1'b0;
               s_d.done = 1'b1;
               if (divZero) begin
                  s_d.errDiv0 = 1'b1;
               end else begin
                  unique case (s_q.cmd)
                     CMD_DIST: s_d.pulses = quoSat;
                     CMD_SPEED: begin
                        s_d.freq = clampTo(quoSat, speedLimit);
                        s_d.clamped = (quoSat > speedLimit);
                     end
                     default: begin
                        s_d.maxFreq = clampTo(quoSat, FREQ_MAX_HZ);
                        s_d.clamped = (quoSat > FREQ_MAX_HZ);
                     end
                  endcase
               end
            end
         end
      endcase
      // Done drops as soon as a new arithmetic conversion is under way.
      if (s_d.busy) begin
         s_d.done = 1'b0;
      end
   end

   // State register with synchronous reset.
   // Unit, per-revolution and maximum speed settings come up nonzero, so a conversion started
   // before any setup still divides by a usable travel; flags, input value, pulses and freq start at zero, maxFreq at RST_MAXFREQ.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         s_q <= '0;
         s_q.unitSystem <= RST_UNIT;
         s_q.pulsesPerRev <= RST_PPR;
         s_q.travelPerRev <= RST_TRAVEL;
         s_q.maxSpeed <= RST_MAXSPD;
         s_q.maxFreq <= RST_MAXFREQ;
         s_q.cmd <= CMD_NONE;
         s_q.st <= ST_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs come straight from the state register; results keep their
   // value until the next conversion of the same kind.
   assign rdData = s_q.rdata;
   assign pulseCount = s_q.pulses;
   assign pulseFreq = s_q.freq;
   assign convBusy = s_q.busy;
   assign convDone = s_q.done;
endmodule

// File: verification/pucv_unit_conv_chk.sv
// Assertion checker for the unit conversion block.
// Assumes it is bound to pucv_unit_conv and sees only its ports.
`timescale 1ns/100ps
module pucv_unit_conv_chk
   import pucv_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire pucv_bus_type busReq,
   input wire logic [31:0] rdData,
   input wire logic [31:0] pulseCount,
   input wire logic [31:0] pulseFreq,
   input wire logic convBusy,
   input wire logic convDone
);
   logic [1:0] unit_q;
   logic [31:0] value_q;
   logic [31:0] travel_q;
   logic start;
   logic arith;

   // Shadows of the unit code, travel and input value settings.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         unit_q <= RST_UNIT;
         value_q <= 32'h00000000;
         travel_q <= RST_TRAVEL;
      end else if (busReq.wr && busReq.addr == OFS_UNIT) begin
         unit_q <= busReq.wdata[1:0];
      end else if (busReq.wr && busReq.addr == OFS_VALUE) begin
         value_q <= busReq.wdata;
      end else if (busReq.wr && busReq.addr == OFS_TRAVEL) begin
         travel_q <= busReq.wdata;
      end
   end

   // A command taken now, and whether it goes down the arithmetic path.
   assign start = busReq.wr && busReq.addr == OFS_CTRL &&
      busReq.wdata[1:0] != 2'h0 && !convBusy;
   assign arith = unit_q == UNIT_MECH ||
      (unit_q == UNIT_COMP && busReq.wdata[1:0] == CMD_DIST);

   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);

   a_unit_readback: assert property (
      busReq.rd && busReq.addr == OFS_UNIT |=> rdData == {30'h0, unit_q})
      else $error("unit code read back wrong");
   a_arith_start: assert property (
      start && arith |=> convBusy && !convDone)
      else $error("arithmetic conversion did not start");
   a_motor_pass: assert property (
      start && unit_q == UNIT_MOTOR |=> convDone && !convBusy)
      else $error("motor unit command not passed through");
   a_motor_dist: assert property (
      start && unit_q == UNIT_MOTOR && busReq.wdata[1:0] == CMD_DIST
      |=> pulseCount == value_q)
      else $error("motor distance not taken as pulses");
   a_comp_speed: assert property (
      start && unit_q == UNIT_COMP && busReq.wdata[1:0] != CMD_DIST
      |=> convDone && !convBusy)
      else $error("composite speed not taken directly");
   a_conv_latency: assert property (
      $fell(convBusy) && convDone && travel_q != 32'h00000000
      |-> $past(convBusy, 84) && !$past(convBusy, 85))
      else $error("conversion run length wrong");
   a_div0_latency: assert property (
      $fell(convBusy) && travel_q == 32'h00000000
      |-> $past(convBusy, 4) && !$past(convBusy, 5))
      else $error("zero divisor run length wrong");
   a_interp_limit: assert property (
      start && busReq.wdata[CTRL_INTERP_BIT] &&
      busReq.wdata[1:0] == CMD_SPEED &&
      (unit_q == UNIT_MOTOR || unit_q == UNIT_COMP)
      |=> pulseFreq <= FREQ_INTERP_HZ)
      else $error("interpolated speed above its ceiling");
   a_result_hold: assert property (
      convBusy |-> $stable(pulseCount) && $stable(pulseFreq))
      else $error("result changed while busy");
   a_freq_ceiling: assert property (
      pulseFreq <= FREQ_MAX_HZ)
      else $error("output frequency above ceiling");

   c_arith: cover property (start && arith);
   c_pass: cover property (start && !arith);
   c_finish: cover property ($fell(convBusy));
endmodule

bind pucv_unit_conv pucv_unit_conv_chk i_chk (.mclk(mclk), .nrst(nrst),
   .busReq(busReq), .rdData(rdData), .pulseCount(pulseCount),
   .pulseFreq(pulseFreq), .convBusy(convBusy), .convDone(convDone));

// File: verification/pucv_servo_model.sv
// Behavioural servo amplifier that takes the commanded pulse rate.
// Assumes pulseFreq is the unit's registered output on the same clock.
`timescale 1ns/100ps
module pucv_servo_model
   import pucv_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [31:0] pulseFreq,
   output logic overLimit
);
   logic overLimit_q;

   // Latches any commanded rate above what the amplifier accepts.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         overLimit_q <= 1'b0;
      end else if (pulseFreq > FREQ_MAX_HZ) begin
         overLimit_q <= 1'b1;
      end
   end
   assign overLimit = overLimit_q;
endmodule

// File: verification/testbench.sv
// Self-checking testbench of the unit conversion block.
// Assumes the checker binds itself and the servo model sits at the outputs.
`timescale 1ns/100ps
module testbench
   import pucv_pkg::*;
;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   pucv_bus_type busReq = '0;
   logic [31:0] rdData;
   logic [31:0] pulseCount;
   logic [31:0] pulseFreq;
   logic [31:0] rdv;
   logic convBusy;
   logic convDone;
   logic overLimit;
   int err_count = 0;
   int checks = 0;
   int cycles = 0;

   always #5 mclk = ~mclk;

   pucv_unit_conv #(.TWO_AXIS(1'b1), .NUM_W(80), .DEN_W(40)) i_dut (
      .mclk(mclk), .nrst(nrst), .busReq(busReq), .rdData(rdData),
      .pulseCount(pulseCount), .pulseFreq(pulseFreq),
      .convBusy(convBusy), .convDone(convDone));
   pucv_servo_model i_servo (.mclk(mclk), .nrst(nrst),
      .pulseFreq(pulseFreq), .overLimit(overLimit));

   // Ends the run with the verdict.
   task automatic test_done();
      if (err_count == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Compares a seen value with the expected one.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One-cycle write strobe beside address and data.
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      busReq.addr <= a;
      busReq.wdata <= d;
      busReq.wr <= 1'b1;
      @(posedge mclk);
      busReq.wr <= 1'b0;
   endtask

   // One-cycle read strobe; data is sampled in the following cycle.
   task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
      @(posedge mclk);
      busReq.addr <= a;
      busReq.rd <= 1'b1;
      @(posedge mclk);
      busReq.rd <= 1'b0;
      @(negedge mclk);
      d = rdData;
   endtask

   // Reads a register and compares it.
   task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
      rd_reg(a, rdv);
      check(rdv, exp);
   endtask

   // Waits, bounded, for the conversion sequencer to go idle.
   task automatic wait_idle();
      int i;
      for (i = 0; i < 100; i++) begin
         @(negedge mclk);
         if (convBusy === 1'b0) break;
      end
      if (i == 100) err_count++;
   endtask

   // Issues a conversion command and waits for it to finish.
   task automatic conv(input logic ip, input pucv_cmd_type c);
      wr_reg(OFS_CTRL, {29'h0, ip, c});
      wait_idle();
   endtask

   // Cuts a hang short.
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         test_done();
      end
   end

   // Main sequence: reset values, then each unit system in turn.
   initial begin
      repeat (4) @(posedge mclk);
      nrst <= 1'b1;
      rchk(OFS_UNIT, 32'h00000002);
      rchk(OFS_PPR, 32'h00000FA0);
      rchk(OFS_TRAVEL, 32'h00001388);
      rchk(OFS_MAXFREQ, 32'h00030D40);
      rchk(4'hF, 32'h00000000);
      wr_reg(OFS_UNIT, 32'h00000000);
      wr_reg(OFS_PPR, 32'h00000FA0);
      wr_reg(OFS_TRAVEL, 32'h00001388);
      wr_reg(OFS_VALUE, 32'h00030D40);
      wr_reg(OFS_CTRL, {30'h0, CMD_DIST});
      wr_reg(OFS_CTRL, {30'h0, CMD_SPEED});
      wait_idle();
      check(pulseCount, 32'h00027100);
      check(pulseFreq, 32'h00000000);
      rchk(OFS_PULSES, 32'h00027100);
      wr_reg(OFS_VALUE, 32'h0000001E);
      conv(1'b0, CMD_SPEED);
      check(pulseFreq, 32'h00000FA0);
      wr_reg(OFS_VALUE, 32'h00000007);
      conv(1'b0, CMD_DIST);
      check(pulseCount, 32'h00000005);
      wr_reg(OFS_MAXSPD, 32'h00001770);
      conv(1'b0, CMD_MAXSPD);
      rchk(OFS_MAXFREQ, 32'h00030D40);
      rd_reg(OFS_STATUS, rdv);
      check(rdv & 32'h00000010, 32'h00000010);
      wr_reg(OFS_UNIT, 32'h00000001);
      wr_reg(OFS_PPR, 32'h00000007);
      rchk(OFS_UNIT, 32'h00000001);
      wr_reg(OFS_VALUE, 32'h0001E240);
      conv(1'b0, CMD_DIST);
      check(pulseCount, 32'h0001E240);
      wr_reg(OFS_VALUE, 32'h0000C350);
      conv(1'b0, CMD_SPEED);
      check(pulseFreq, 32'h0000C350);
      wr_reg(OFS_VALUE, 32'h000249F0);
      conv(1'b1, CMD_SPEED);
      check(pulseFreq, 32'h000186A0);
      wr_reg(OFS_MAXSPD, 32'h000493E0);
      conv(1'b0, CMD_MAXSPD);
      rchk(OFS_MAXFREQ, 32'h00030D40);
      wr_reg(OFS_UNIT, 32'h00000002);
      wr_reg(OFS_PPR, 32'h00000FA0);
      wr_reg(OFS_VALUE, 32'h00030D40);
      conv(1'b0, CMD_DIST);
      check(pulseCount, 32'h00027100);
      wr_reg(OFS_VALUE, 32'h00000FA0);
      conv(1'b0, CMD_SPEED);
      check(pulseFreq, 32'h00000FA0);
      wr_reg(OFS_UNIT, 32'h00000003);
      conv(1'b0, CMD_DIST);
      rd_reg(OFS_STATUS, rdv);
      check(rdv & 32'h00000008, 32'h00000008);
      wr_reg(OFS_UNIT, 32'h00000000);
      wr_reg(OFS_TRAVEL, 32'h00000000);
      conv(1'b0, CMD_DIST);
      check(pulseCount, 32'h00027100);
      rd_reg(OFS_STATUS, rdv);
      check(rdv & 32'h00000004, 32'h00000004);
      check({31'h0, overLimit}, 32'h00000000);
      test_done();
   end
endmodule
